// *** mmcs_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mmcs_fifo
  import mmcs_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire logic wr_fire = in_valid && in_ready;
  wire logic rd_fire = out_valid && out_ready;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge core_clk)
  begin
    if (wr_fire)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (wr_fire)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (rd_fire)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(wr_fire) - (AW+1)'(rd_fire);
    end
  end
endmodule
`default_nettype wire

// *** mmcs_host.sv ***
// Host model for the single-wire monitor link.
// Assumes a pulled-up line; the model only ever pulls it low.
`timescale 1ns/1ps
`default_nettype none
module mmcs_host
  import mmcs_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Serial line
  input wire logic line,
  output logic drive_low,
  // Received frames
  output logic rx_valid,
  output var mmcs_tx_item_t rx_item
);
  logic sending;
  logic armed;
  logic busy;
  logic [9:0] sh;
  int cnt;
  int nb;
  int rx_count;

  initial
  begin
    drive_low = 1'b0;
    sending = 1'b0;
    rx_valid = 1'b0;
    rx_item = '0;
    armed = 1'b0;
    busy = 1'b0;
    sh = '0;
    cnt = 0;
    nb = 0;
    rx_count = 0;
  end

  task automatic tx_bit(input logic b);
    drive_low = ~b;
    repeat (BIT_DIV) @(posedge core_clk);
    #1;
  endtask

  // ****************************************
  // Transmit one byte
  // ****************************************
  task automatic send_byte(input logic [7:0] d);
    int i;
    int start;
    sending = 1'b1;
    tx_bit(1'b0);
    for (i = 0; i < 8; i++)
      tx_bit(d[i]);
    tx_bit(1'b1);
    sending = 1'b0;
    start = rx_count;
    for (i = 0; i < 30 * BIT_DIV && rx_count == start; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    repeat (BIT_DIV) @(posedge core_clk);
    #1;
  endtask

  // ****************************************
  // Receiver, mid-bit sampling
  // ****************************************
  // frame decode, break when all low
  always @(posedge core_clk)
  begin
    rx_valid <= 1'b0;
    if (!busy)
    begin
      if (line)
        armed <= 1'b1;
      else if (armed && !sending)
      begin
        busy <= 1'b1;
        cnt <= BIT_DIV / 2;
        nb <= 0;
      end
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else
    begin
      cnt <= BIT_DIV;
      sh <= {line, sh[9:1]};
      nb <= nb + 1;
      if (nb == 9)
      begin
        busy <= 1'b0;
        armed <= 1'b0;
        rx_valid <= 1'b1;
        rx_item.data <= sh[9:2];
        rx_item.brk <= ~line && (sh[9:2] == 8'h00);
        rx_count <= rx_count + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** mmcs_monitor.sv ***
// Monitor-mode command responder and security gate.
// Assumes a memory port with one cycle of read latency and a CPU that
// acts on the trap and resume pulses; serial pin is open-drain style.
// Summary of operation
// - Echo each accepted byte after two bit times
// - Wait eleven bit times before executing command
// - Indexed commands step through consecutive addresses
// - Entry issues one trap push pulse, then security wait or idle
// - Run reads stacked PC high then low, then pulses return
// - Stack pointer read returns SP plus one
// - Stacked PC sits at SP+5, SP+6
// - Pass only if eight bytes match protected
// - After power-on, wait for eight security bytes
// - Bypass survives every reset except power-on
// - Failed: flash reads invalid, fetch resets
// - Send break after all eight security bytes
// - Set RAM flag bit when code correct
// - Mass erase writes erased value to locations
// - Break is start plus nine zero bits
// - Bit rate is bus clock over 256
// - Echo bytes received in SEC, IDLE or ARG state on same pin; others dropped
// - Read data follows echo of last byte
`timescale 1ns/1ps
`default_nettype none
module mmcs_monitor
  import mmcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic por_rst,
  // Serial pin
  input wire logic monitor_serial_pin_i,
  output logic monitor_serial_pin_o,
  output logic monitor_serial_pin_oe,
  // Memory port
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  // CPU side
  input wire logic [15:0] cpu_sp,
  input wire logic cpu_flash_fetch,
  input wire logic mass_erase_req,
  output logic cpu_trap_push,
  output logic cpu_pull_rti,
  output logic [15:0] resume_pc,
  output logic flash_unlocked,
  output logic illegal_addr_rst
);

  // ****************************************
  // Bit-rate divider
  // ****************************************
  logic [7:0] div_q;
  wire logic bit_tick = (div_q == BIT_TOP);

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      div_q <= '0;
    else
      div_q <= div_q + 8'h01;
  end

  // ****************************************
  // Receiver
  // ****************************************
  logic rx_s1_q, rx_s2_q, rx_arm_q, rx_act_q;
  logic [7:0] rx_ph_q;
  logic [3:0] rx_n_q;
  logic [8:0] rx_sh_q;
  logic rx_byte_q, rx_brk_q;
  logic [7:0] rx_data_q;
  logic tx_busy_q;
  // Own echo must not be heard as host data
  wire logic rx_start = rx_arm_q && !rx_act_q && !rx_s2_q && !tx_busy_q;
  wire logic rx_samp = rx_act_q && (rx_ph_q == HALF_BIT);
  wire logic rx_end = rx_samp && (rx_n_q == RX_LAST);

  always_ff @(posedge core_clk)
  begin
    rx_s1_q <= monitor_serial_pin_i;
    rx_s2_q <= rx_s1_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rx_arm_q <= 1'b0;
      rx_act_q <= 1'b0;
      rx_ph_q <= '0;
      rx_n_q <= '0;
      rx_sh_q <= '0;
      rx_byte_q <= 1'b0;
      rx_brk_q <= 1'b0;
      rx_data_q <= '0;
    end
    else
    begin
      rx_byte_q <= 1'b0;
      rx_brk_q <= 1'b0;
      rx_ph_q <= rx_start ? 8'h00 : rx_ph_q + 8'h01;
      if (rx_s2_q && !rx_act_q)
        rx_arm_q <= 1'b1;
      if (rx_start)
      begin
        rx_act_q <= 1'b1;
        rx_arm_q <= 1'b0;
        rx_n_q <= '0;
      end
      else if (rx_samp)
      begin
        rx_n_q <= rx_n_q + 4'h1;
        rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
        if (rx_n_q == 4'h0 && rx_s2_q)
          rx_act_q <= 1'b0;
        if (rx_end)
        begin
          rx_act_q <= 1'b0;
          rx_data_q <= rx_sh_q[8:1];
          rx_byte_q <= rx_s2_q;
          rx_brk_q <= !rx_s2_q && (rx_sh_q[8:1] == 8'h00);
        end
      end
    end
  end

  // ****************************************
  // Transmit queue and transmitter
  // ****************************************
  mmcs_tx_item_t q_in, q_out;
  logic q_in_valid, q_in_ready, q_out_valid;
  logic [3:0] tx_cnt_q;
  logic [9:0] tx_sh_q;
  logic pin_o_q, pin_oe_q;
  wire logic q_pop = q_out_valid && !tx_busy_q;
  wire logic tx_frame = tx_busy_q && (tx_cnt_q >= ECHO_GAP_BITS);
  wire logic tx_done = tx_busy_q && bit_tick && (tx_cnt_q == TX_LAST);

  mmcs_fifo #(.WIDTH($bits(mmcs_tx_item_t)), .DEPTH(TXQ_DEPTH)) u_txq (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .in_data(q_in),
    .out_valid(q_out_valid),
    .out_ready(!tx_busy_q),
    .out_data(q_out)
  );

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_sh_q <= '1;
      pin_o_q <= 1'b1;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      if (q_pop)
      begin
        tx_busy_q <= 1'b1;
        tx_cnt_q <= '0;
        tx_sh_q <= q_out.brk ? 10'h000 : {1'b1, q_out.data, 1'b0};
      end
      else if (tx_done)
        tx_busy_q <= 1'b0;
      else if (tx_busy_q && bit_tick)
      begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
        if (tx_frame)
          tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      end
      pin_o_q <= tx_frame ? tx_sh_q[0] : 1'b1;
      pin_oe_q <= tx_busy_q && !tx_done;
    end
  end

  // ****************************************
  // Command and security sequencer
  // ****************************************
  mmcs_state_t state_q, state_d;
  logic pend_v_q;
  logic [7:0] pend_d_q, cmd_q, dat_q, out_q;
  logic [15:0] addr_q, index_q, sp_plus1;
  logic [1:0] argn_q, rd_left_q;
  logic [2:0] secn_q;
  logic [3:0] cnt_q;
  logic miss_q, sec_q;
  logic [15:0] maddr_q;
  logic [7:0] mwdata_q, pc_hi_q;
  logic mwe_q, mre_q, trap_q, rti_q, illeg_q;
  logic [15:0] pc_q;

  wire logic acc_st = (state_q == S_SEC) || (state_q == S_IDLE) ||
                      (state_q == S_ARG);
  wire logic want_echo = pend_v_q && acc_st;
  wire logic push_brk = (state_q == S_SBRK) || (state_q == S_BRKE);
  wire logic push_dat = (state_q == S_PUSH);
  wire logic echo_fire = want_echo && q_in_ready;
  wire logic push_fire = q_in_valid && q_in_ready;
  wire logic tx_quiet = !tx_busy_q && !q_out_valid;
  wire logic [15:0] rd_addr = (cmd_q == CMD_READ) ?
                              {addr_q[7:0], dat_q} : addr_q;
  wire logic flash_hidden = !sec_q && (maddr_q >= FLASH_BASE);
  wire logic [1:0] argc = (cmd_q == CMD_READ) ? 2'd2 :
                          (cmd_q == CMD_WRITE) ? 2'd3 :
                          (cmd_q == CMD_IDX_WR) ? 2'd1 : 2'd0;
  wire logic [1:0] arg_new = (pend_d_q == CMD_READ) ? 2'd2 :
                             (pend_d_q == CMD_WRITE) ? 2'd3 :
                             (pend_d_q == CMD_IDX_WR) ? 2'd1 : 2'd0;
  wire logic known_cmd = (pend_d_q >= CMD_READ) && (pend_d_q <= CMD_RUN);

  assign sp_plus1 = cpu_sp + SP_RD_INC;
  // Echo and read data share the queue
  assign q_in_valid = want_echo || push_brk || push_dat;
  assign q_in.brk = push_brk;
  assign q_in.data = push_dat ? out_q : pend_d_q;
  assign argn_q = argc;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_ENTRY: state_d = sec_q ? S_IDLE : S_SEC;
      S_SEC: if (echo_fire) state_d = S_SRD;
      S_SRD: state_d = S_SCMP;
      S_SCMP: state_d = (secn_q == SEC_LAST) ? S_SFLAG : S_SEC;
      // Break only after the eighth compare
      S_SFLAG: state_d = S_SBRK;
      S_SBRK: if (push_fire) state_d = S_IDLE;
      S_IDLE:
      begin
        if (mass_erase_req && !sec_q)
          state_d = S_ERASE;
        else if (rx_brk_q)
          state_d = S_BRKE;
        else if (echo_fire && known_cmd)
          state_d = (arg_new == 2'd0) ? S_CANCEL : S_ARG;
      end
      S_ARG:
      begin
        if (rx_brk_q)
          state_d = S_BRKE;
        else if (echo_fire && cnt_q[1:0] == argn_q - 2'd1)
          state_d = S_CANCEL;
      end
      S_CANCEL:
      begin
        if (rx_brk_q)
          state_d = S_BRKE;
        else if (cnt_q == CANCEL_BITS)
          state_d = S_EXEC;
      end
      S_EXEC:
      begin
        if (cmd_q == CMD_READ || cmd_q == CMD_IDX_RD)
          state_d = S_RDS;
        else if (cmd_q == CMD_SP_RD)
          state_d = S_PUSH;
        else if (cmd_q == CMD_RUN)
          state_d = S_RUN1;
        else
          state_d = S_IDLE;
      end
      S_RDS: state_d = S_RDW;
      S_RDW: state_d = S_RDGET;
      S_RDGET: state_d = S_PUSH;
      S_PUSH:
      begin
        if (push_fire)
          state_d = (rd_left_q == 2'd1) ? S_IDLE :
                    (cmd_q == CMD_SP_RD) ? S_PUSH : S_RDS;
      end
      S_RUN1: state_d = S_RUN2;
      S_RUN2: state_d = S_RUN3;
      S_RUN3: state_d = S_IDLE;
      S_BRKE: if (push_fire) state_d = S_IDLE;
      S_ERASE: if (secn_q == SEC_LAST) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      state_q <= S_ENTRY;
    else
      state_q <= state_d;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn && por_rst)
      sec_q <= 1'b0;
    else if (resetn && state_q == S_SFLAG)
      sec_q <= !miss_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pend_v_q <= 1'b0;
      pend_d_q <= '0;
      cmd_q <= '0;
      dat_q <= '0;
      out_q <= '0;
      addr_q <= '0;
      index_q <= '0;
      rd_left_q <= '0;
      secn_q <= '0;
      cnt_q <= '0;
      miss_q <= 1'b0;
      maddr_q <= '0;
      mwdata_q <= '0;
      mwe_q <= 1'b0;
      mre_q <= 1'b0;
      trap_q <= 1'b0;
      rti_q <= 1'b0;
      illeg_q <= 1'b0;
      pc_hi_q <= '0;
      pc_q <= '0;
    end
    else
    begin
      mwe_q <= 1'b0;
      mre_q <= 1'b0;
      rti_q <= 1'b0;
      trap_q <= (state_q == S_ENTRY);
      illeg_q <= cpu_flash_fetch && !sec_q;
      // A new byte wins over the consume
      if (rx_byte_q)
      begin
        pend_v_q <= 1'b1;
        pend_d_q <= rx_data_q;
      end
      else if (echo_fire || (pend_v_q && !acc_st))
        pend_v_q <= 1'b0;
      case (state_q)
        S_SEC:
        begin
          if (echo_fire)
          begin
            dat_q <= pend_d_q;
            maddr_q <= SEC_BASE + {13'h0000, secn_q};
            mre_q <= 1'b1;
          end
        end
        S_SCMP:
        begin
          if (mem_rdata != dat_q)
            miss_q <= 1'b1;
          secn_q <= secn_q + 3'h1;
        end
        S_SFLAG:
        begin
          maddr_q <= SEC_FLAG_ADDR;
          mwdata_q <= miss_q ? 8'h00 : SEC_FLAG_MASK;
          mwe_q <= 1'b1;
        end
        S_IDLE:
        begin
          cnt_q <= '0;
          secn_q <= '0;
          if (echo_fire)
            cmd_q <= pend_d_q;
        end
        S_ARG:
        begin
          if (echo_fire)
          begin
            {addr_q, dat_q} <= {addr_q[7:0], dat_q, pend_d_q};
            cnt_q <= cnt_q + 4'h1;
          end
          if (state_d == S_CANCEL)
            cnt_q <= '0;
        end
        S_CANCEL:
          if (tx_quiet && bit_tick)
            cnt_q <= cnt_q + 4'h1;
        S_EXEC:
        begin
          if (cmd_q == CMD_READ)
          begin
            index_q <= rd_addr;
            rd_left_q <= 2'd1;
          end
          else if (cmd_q == CMD_IDX_RD)
            rd_left_q <= 2'd2;
          else if (cmd_q == CMD_SP_RD)
          begin
            rd_left_q <= 2'd2;
            out_q <= sp_plus1[15:8];
          end
          else if (cmd_q == CMD_WRITE || cmd_q == CMD_IDX_WR)
          begin
            maddr_q <= (cmd_q == CMD_WRITE) ? addr_q : index_q;
            index_q <= ((cmd_q == CMD_WRITE) ? addr_q : index_q) + 16'h0001;
            mwdata_q <= dat_q;
            mwe_q <= 1'b1;
          end
          else if (cmd_q == CMD_RUN)
          begin
            maddr_q <= cpu_sp + PC_HI_OFS;
            mre_q <= 1'b1;
          end
        end
        S_RDS:
        begin
          maddr_q <= index_q;
          mre_q <= 1'b1;
          index_q <= index_q + 16'h0001;
        end
        S_RDGET: out_q <= flash_hidden ? INVALID_BYTE : mem_rdata;
        S_PUSH:
        begin
          if (push_fire)
          begin
            rd_left_q <= rd_left_q - 2'd1;
            out_q <= sp_plus1[7:0];
          end
        end
        S_RUN1:
        begin
          maddr_q <= cpu_sp + PC_LO_OFS;
          mre_q <= 1'b1;
        end
        S_RUN2: pc_hi_q <= mem_rdata;
        S_RUN3:
        begin
          pc_q <= {pc_hi_q, mem_rdata};
          rti_q <= 1'b1;
        end
        S_ERASE:
        begin
          maddr_q <= SEC_BASE + {13'h0000, secn_q};
          mwdata_q <= ERASED_BYTE;
          mwe_q <= 1'b1;
          secn_q <= secn_q + 3'h1;
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign monitor_serial_pin_o = pin_o_q;
  assign monitor_serial_pin_oe = pin_oe_q;
  assign mem_addr = maddr_q;
  assign mem_wdata = mwdata_q;
  assign mem_we = mwe_q;
  assign mem_re = mre_q;
  assign cpu_trap_push = trap_q;
  assign cpu_pull_rti = rti_q;
  assign resume_pc = pc_q;
  assign flash_unlocked = sec_q;
  assign illegal_addr_rst = illeg_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  echo_gap_a: assert property (
    q_pop |-> ##2 (pin_oe_q && pin_o_q)[*8]) else $error("echo gap broken");
  cancel_wait_a: assert property (
    (state_q == S_EXEC) |->
    $past(state_q) == S_CANCEL && $past(cnt_q) == CANCEL_BITS)
    else $error("command acted early");
  index_step_a: assert property (
    (state_q == S_RDS || (state_q == S_EXEC && cmd_q == CMD_IDX_WR)) |=>
    index_q == $past(index_q) + 16'h0001) else $error("index not stepped");
  sp_plus_a: assert property (
    (state_q == S_EXEC && cmd_q == CMD_SP_RD) |=>
    out_q == $past(cpu_sp[15:8] + 8'(cpu_sp[7:0] == 8'hFF)))
    else $error("sp read wrong");
  run_order_a: assert property (
    $rose(rti_q) |-> $past(state_q, 1) == S_RUN3 && $past(mre_q, 2))
    else $error("resume out of order");
  fetch_rst_a: assert property (
    (cpu_flash_fetch && !sec_q) |=> illeg_q) else $error("no illegal reset");
  brk_after_a: assert property (
    (push_fire && state_q == S_SBRK) |-> $past(secn_q, 3) == SEC_LAST)
    else $error("break before eight bytes");
  flag_bit_a: assert property (
    (mwe_q && maddr_q == SEC_FLAG_ADDR && $past(state_q) == S_SFLAG)
    |-> mwdata_q[6] == sec_q) else $error("flag mismatch");
  erase_val_a: assert property (
    (state_q == S_ERASE) |=> mwe_q && mwdata_q == ERASED_BYTE)
    else $error("erase value wrong");

  sec_pass_c: cover property (state_q == S_SFLAG && !miss_q);
  read_cmd_c: cover property (push_fire && push_dat && cmd_q == CMD_READ);
  run_cmd_c: cover property (rti_q);
  cancel_c: cover property (state_q == S_CANCEL && rx_brk_q);
endmodule
`default_nettype wire

// *** mmcs_pkg.sv ***
// Shared constants and types of the monitor command and security block.
// Assumes one bus clock; serial bit time is a fixed division of it.
package mmcs_pkg;

  // ****************************************
  // Serial timing, in bus clock cycles (BIT_DIV, BIT_TOP, HALF_BIT) and in bit times (the rest)
  // ****************************************
  localparam int BIT_DIV = 256;
  localparam logic [7:0] BIT_TOP = 8'(BIT_DIV - 1);
  localparam logic [7:0] HALF_BIT = 8'(BIT_DIV / 2);
  localparam logic [3:0] ECHO_GAP_BITS = 4'h2;
  localparam logic [3:0] CANCEL_BITS = 4'hB;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] TX_LAST = 4'(ECHO_GAP_BITS + FRAME_BITS - 4'h1);
  localparam logic [3:0] RX_LAST = 4'h9;

  // ****************************************
  // Memory map and security
  // ****************************************
  localparam logic [15:0] SEC_BASE = 16'hFFF6;
  localparam logic [2:0] SEC_LAST = 3'h7;
  localparam logic [15:0] SEC_FLAG_ADDR = 16'h0040;
  localparam logic [7:0] SEC_FLAG_MASK = 8'h40;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] FLASH_BASE = 16'h8000;
  localparam logic [7:0] INVALID_BYTE = 8'hAD;
  localparam logic [15:0] SP_RD_INC = 16'h0001;
  localparam logic [15:0] PC_HI_OFS = 16'h0005;
  localparam logic [15:0] PC_LO_OFS = 16'h0006;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_IDX_RD = 8'h03;
  localparam logic [7:0] CMD_IDX_WR = 8'h04;
  localparam logic [7:0] CMD_SP_RD = 8'h05;
  localparam logic [7:0] CMD_RUN = 8'h06;

  // ****************************************
  // Buffer and types
  // ****************************************
  localparam int TXQ_DEPTH = 8;

  typedef struct packed {
    logic brk;
    logic [7:0] data;
  } mmcs_tx_item_t;

  typedef enum logic [4:0] {
    S_ENTRY, S_SEC, S_SRD, S_SCMP, S_SFLAG, S_SBRK, S_IDLE, S_ARG,
    S_CANCEL, S_EXEC, S_RDS, S_RDW, S_RDGET, S_PUSH, S_RUN1, S_RUN2,
    S_RUN3, S_BRKE, S_ERASE
  } mmcs_state_t;

endpackage

// *** testbench.sv ***
// Self-checking bench for the monitor responder and security gate.
// Assumes a flat 64K memory model with one cycle of read latency.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mmcs_pkg::*;
  localparam int LIMIT = 99000;
  logic core_clk, resetn, por_rst, pin_o, pin_oe, host_low, line;
  logic [15:0] mem_addr, cpu_sp, resume_pc, addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic mem_we, mem_re, trap, pull, unlocked, ill, rx_valid, fetch;
  mmcs_tx_item_t rx_item;
  logic [7:0] mem [0:65535];
  mmcs_tx_item_t exp_q[$];
  logic [15:0] pc_q[$];
  int n_errors, checks, seed, cycles;

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  // Pull-up: low only while someone pulls
  assign line = ~((pin_oe & ~pin_o) | host_low);
  // Read data follows the read strobe by one cycle
  always @(posedge core_clk)
  begin
    if (mem_re)
      mem_rdata <= mem[mem_addr];
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end

  mmcs_monitor u_dut (.core_clk(core_clk), .resetn(resetn),
    .por_rst(por_rst), .monitor_serial_pin_i(line),
    .monitor_serial_pin_o(pin_o), .monitor_serial_pin_oe(pin_oe),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata), .cpu_sp(cpu_sp),
    .cpu_flash_fetch(fetch), .mass_erase_req(1'b0),
    .cpu_trap_push(trap), .cpu_pull_rti(pull), .resume_pc(resume_pc),
    .flash_unlocked(unlocked), .illegal_addr_rst(ill));

  mmcs_host u_host (.core_clk(core_clk), .line(line),
    .drive_low(host_low), .rx_valid(rx_valid), .rx_item(rx_item));

  // ****************************************
  // Compare and report
  // ****************************************
  task automatic check_item(input string what, input mmcs_tx_item_t exp,
                            input mmcs_tx_item_t got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_word(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // Stimulus helpers
  // ****************************************
  task automatic send(input logic [7:0] b);
    exp_q.push_back({1'b0, b});
    u_host.send_byte(b);
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 40 * BIT_DIV && exp_q.size() != 0; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    check_word("reply_queue", 16'h0000, 16'(exp_q.size()));
    repeat (BIT_DIV) @(posedge core_clk);
    #1;
  endtask

  task automatic apply_reset(input logic por);
    resetn = 1'b0;
    por_rst = por;
    repeat (8) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    @(posedge core_clk);
    #1;
    por_rst = 1'b0;
    check_word("trap_push", 16'h0001, {15'h0000, trap});
  endtask

  task automatic pulse_fetch(input logic exp);
    fetch = 1'b1;
    @(posedge core_clk);
    #1;
    fetch = 1'b0;
    check_word("illegal_reset", {15'h0000, exp}, {15'h0000, ill});
  endtask

  // ****************************************
  // Output watchers
  // ****************************************
  always @(posedge core_clk)
  begin
    if (rx_valid && exp_q.size() == 0)
    begin
      n_errors++;
      $display("unexpected serial_extra: expected none seen %h", rx_item);
    end
    else if (rx_valid)
      check_item("serial_byte", exp_q.pop_front(), rx_item);
    if (pull && pc_q.size() != 0)
      check_word("resume_pc", pc_q.pop_front(), resume_pc);
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_errors++;
      $display("unexpected run_cycles: expected %0d seen %0d", LIMIT - 1,
               cycles);
      final_report();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 63;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    fetch = 1'b0;
    resetn = 1'b0;
    por_rst = 1'b1;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'($random(seed));
    mem[SEC_FLAG_ADDR] = 8'h00;
    cpu_sp = {8'h01, 8'($random(seed))};
    apply_reset(1'b1);
    pulse_fetch(1'b1);
    for (int i = 0; i < 8; i++)
      send(mem[SEC_BASE + 16'(i)]);
    exp_q.push_back({1'b1, 8'h00});
    drain();
    check_word("flash_unlocked", 16'h0001, {15'h0000, unlocked});
    check_word("flag_byte", {8'h00, SEC_FLAG_MASK},
               {8'h00, mem[SEC_FLAG_ADDR] & SEC_FLAG_MASK});
    addr = FLASH_BASE | 16'($random(seed) & 32'h7FFF);
    send(CMD_READ);
    send(addr[15:8]);
    send(addr[7:0]);
    exp_q.push_back({1'b0, mem[addr]});
    drain();
    addr = cpu_sp + SP_RD_INC;
    send(CMD_SP_RD);
    exp_q.push_back({1'b0, addr[15:8]});
    exp_q.push_back({1'b0, addr[7:0]});
    drain();
    // Bench writes a new stacked PC low byte straight into memory
    mem[cpu_sp + PC_LO_OFS] = 8'($random(seed));
    pc_q.push_back({mem[cpu_sp + PC_HI_OFS], mem[cpu_sp + PC_LO_OFS]});
    send(CMD_RUN);
    check_word("run_early", 16'h0001, 16'(pc_q.size()));
    for (int i = 0; i < 16 * BIT_DIV && pc_q.size() != 0; i++)
      @(posedge core_clk);
    #1;
    check_word("run_pulse", 16'h0000, 16'(pc_q.size()));
    apply_reset(1'b0);
    check_word("flash_kept", 16'h0001, {15'h0000, unlocked});
    pulse_fetch(1'b0);
    final_report();
  end
endmodule
`default_nettype wire
